/* tpioc_params.svh */
/*
  Constants of the three-phase instantaneous overcurrent block: register byte offsets,
  field widths, reset values and setting limits.
  Assumes it is included by its bare name from files that use these macros.
*/
`ifndef TPIOC_PARAMS_SVH
`define TPIOC_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave
`define TPIOC_ADDR_CTRL       5'h00
`define TPIOC_ADDR_START      5'h04
`define TPIOC_ADDR_STATUS     5'h08
`define TPIOC_ADDR_IRQ_STATUS 5'h0C
`define TPIOC_ADDR_IRQ_MASK   5'h10

// Field layout
`define TPIOC_MODE_W          2
`define TPIOC_START_W         12
`define TPIOC_THR_W           13
`define TPIOC_MEAS_W          16
`define TPIOC_EVT_W           4
`define TPIOC_NUM_PHASES      3

// Reset values and setting limits (percent)
`define TPIOC_START_MIN       12'h014
`define TPIOC_START_MAX       12'hBB8
`define TPIOC_START_DEFAULT   12'h0C8
`define TPIOC_MASK_DEFAULT    4'h0

`endif

/* tpioc_pkg.sv */
/*
  Types shared by the three-phase instantaneous overcurrent block.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package tpioc_pkg;

  // Operation setting: off, peak-value or fundamental-RMS comparison
  typedef enum logic [1:0] {
    tpioc_mode_off,
    tpioc_mode_peak,
    tpioc_mode_fund
  } tpioc_mode_t;

endpackage

`default_nettype wire

/* tpioc_phase_cmp.sv */
/*
  One phase of the instantaneous decision: selects the measure and compares it
  against the effective threshold.
  Assumes measure and threshold are in the same unit (percent of nominal current).
*/
`timescale 1ns/1ns
`default_nettype none
`include "tpioc_params.svh"

module tpioc_phase_cmp (
  input  wire tpioc_pkg::tpioc_mode_t      mode,
  input  wire logic                        inhibit,
  input  wire logic [`TPIOC_MEAS_W-1:0]    rms_value,
  input  wire logic [`TPIOC_MEAS_W-1:0]    peak_value,
  input  wire logic [`TPIOC_THR_W-1:0]     threshold,
  output logic                             trip
);

  logic [`TPIOC_MEAS_W-1:0] thr_ext;

  // Threshold widened to the measure width
  assign thr_ext = {{(`TPIOC_MEAS_W-`TPIOC_THR_W){1'b0}}, threshold};

  // Strictly-above comparison of the selected measure, no delay added
  always_comb begin
    trip = 1'b0;
    if (!inhibit) begin
      unique case (mode)
        tpioc_pkg::tpioc_mode_off:  trip = 1'b0;
        tpioc_pkg::tpioc_mode_peak: trip = (peak_value > thr_ext);
        tpioc_pkg::tpioc_mode_fund: trip = (rms_value > thr_ext);
        default:                    trip = 1'b0;
      endcase
    end
  end

endmodule

`default_nettype wire

/* tpioc_phase_instant_overcurrent.sv */
/*
  Three-phase instantaneous overcurrent decision with Avalon-MM register access
  and a sticky, maskable interrupt on trip onsets.
  Assumes phase measures arrive synchronous to clk_sys from the upstream peak and
  Fourier stages, and that the bus master follows Avalon-MM with waitrequest.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tpioc_params.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Each phase trips as soon as its selected measure exceeds the effective threshold.
// - Operation setting is off, peak-value or fundamental-RMS; it resets to off.
// - Start current is an integer percentage 20 to 3000, step 1, default 200.
// - Trip follows pickup after only the one-cycle inherent operating time.
// - The inhibit input forces all phase and general trips low.
// - The doubling input compares against twice the configured start current.
// - The general trip is derived from the three phase trip signals.
// - Three independent phase trips, each from its own phase only.
// - General trip is the logical OR of the phase trips.
module tpioc_phase_instant_overcurrent (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // Avalon-MM slave
  input  wire logic [4:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  // Binary inputs
  input  wire logic                        function_inhibit_in,
  input  wire logic                        threshold_doubling_in,
  // Phase measures
  input  wire logic [`TPIOC_MEAS_W-1:0]    phase_a_fundamental_rms,
  input  wire logic [`TPIOC_MEAS_W-1:0]    phase_b_fundamental_rms,
  input  wire logic [`TPIOC_MEAS_W-1:0]    phase_c_fundamental_rms,
  input  wire logic [`TPIOC_MEAS_W-1:0]    phase_a_peak_value,
  input  wire logic [`TPIOC_MEAS_W-1:0]    phase_b_peak_value,
  input  wire logic [`TPIOC_MEAS_W-1:0]    phase_c_peak_value,
  // Trip outputs
  output logic                             phase_a_trip_out,
  output logic                             phase_b_trip_out,
  output logic                             phase_c_trip_out,
  output logic                             any_phase_trip_out,
  output logic                             irq_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int NP = `TPIOC_NUM_PHASES;

  tpioc_pkg::tpioc_mode_t           mode_r;
  tpioc_pkg::tpioc_mode_t           mode_nxt;
  logic [`TPIOC_START_W-1:0]        start_r;
  logic [`TPIOC_START_W-1:0]        start_nxt;
  logic [`TPIOC_EVT_W-1:0]          mask_r;
  logic [`TPIOC_EVT_W-1:0]          mask_nxt;
  logic [`TPIOC_EVT_W-1:0]          irq_r;
  logic [`TPIOC_EVT_W-1:0]          irq_nxt;
  logic                             ack_r;
  logic                             ack_nxt;
  logic [31:0]                      rdata_r;
  logic [31:0]                      rdata_nxt;
  logic [NP-1:0]                    trip_r;
  logic [NP-1:0]                    trip_nxt;
  logic                             any_r;
  logic                             any_nxt;
  logic [`TPIOC_EVT_W-1:0]          evt;
  logic [`TPIOC_THR_W-1:0]          threshold;
  logic [`TPIOC_MEAS_W-1:0]         rms_vec  [NP];
  logic [`TPIOC_MEAS_W-1:0]         peak_vec [NP];
  logic                             wr_take;
  logic                             rd_take;
  logic [31:0]                      start_word;
  logic [31:0]                      mask_word;
  logic [31:0]                      ctrl_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge for partial writes

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Phase decision

  // Effective threshold, doubled on request
  assign threshold = threshold_doubling_in ? {start_r, 1'b0} : {1'b0, start_r};

  // Measures gathered per phase
  assign rms_vec[0]  = phase_a_fundamental_rms;
  assign rms_vec[1]  = phase_b_fundamental_rms;
  assign rms_vec[2]  = phase_c_fundamental_rms;
  assign peak_vec[0] = phase_a_peak_value;
  assign peak_vec[1] = phase_b_peak_value;
  assign peak_vec[2] = phase_c_peak_value;

  // One comparator per phase, each sees only its own measures
  generate
    for (genvar p = 0; p < NP; p++) begin : g_phase
      tpioc_phase_cmp u_cmp (
        .mode       (mode_r),
        .inhibit    (function_inhibit_in),
        .rms_value  (rms_vec[p]),
        .peak_value (peak_vec[p]),
        .threshold  (threshold),
        .trip       (trip_nxt[p])
      );
    end
  endgenerate

  // General trip from the same next values so it never lags a phase
  always_comb begin
    any_nxt = |trip_nxt;
    evt     = {any_nxt & ~any_r, trip_nxt & ~trip_r};
  end

  // Trip registers: the one-cycle inherent operating time
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trip_r <= '0;
      any_r  <= 1'b0;
    end else begin
      trip_r <= trip_nxt;
      any_r  <= any_nxt;
    end
  end

  assign phase_a_trip_out   = trip_r[0];
  assign phase_b_trip_out   = trip_r[1];
  assign phase_c_trip_out   = trip_r[2];
  assign any_phase_trip_out = any_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM handshake

  // Every access waits one cycle, then completes
  assign wr_take         = avs_write & ack_r;
  assign rd_take         = avs_read & ack_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata    = rdata_r;

  // Current register contents as bus words
  assign ctrl_word  = {30'h0000_0000, mode_r};
  assign start_word = {20'h0_0000, start_r};
  assign mask_word  = {28'h000_0000, mask_r};

  // Acknowledge and read data capture
  always_comb begin
    ack_nxt   = (avs_read | avs_write) & ~ack_r;
    rdata_nxt = rdata_r;
    if (avs_read && !ack_r) begin
      unique case (avs_address)
        `TPIOC_ADDR_CTRL:       rdata_nxt = ctrl_word;
        `TPIOC_ADDR_START:      rdata_nxt = start_word;
        `TPIOC_ADDR_STATUS:     rdata_nxt = {28'h000_0000, any_r, trip_r};
        `TPIOC_ADDR_IRQ_STATUS: rdata_nxt = {28'h000_0000, irq_r};
        `TPIOC_ADDR_IRQ_MASK:   rdata_nxt = mask_word;
        default:                rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register file

  // Writes take effect on the completing edge; start current is clamped
  always_comb begin
    logic [31:0] merged;
    logic [1:0]  mode_code;
    merged    = 32'h0000_0000;
    mode_code = 2'h0;
    mode_nxt  = mode_r;
    start_nxt = start_r;
    mask_nxt  = mask_r;
    if (wr_take) begin
      unique case (avs_address)
        `TPIOC_ADDR_CTRL: begin
          merged    = lane_merge(ctrl_word, avs_writedata, avs_byteenable);
          mode_code = merged[1:0];
          if (mode_code == 2'h3) begin
            mode_nxt = tpioc_pkg::tpioc_mode_off;
          end else begin
            mode_nxt = tpioc_pkg::tpioc_mode_t'(mode_code);
          end
        end
        `TPIOC_ADDR_START: begin
          merged = lane_merge(start_word, avs_writedata, avs_byteenable);
          if (merged[31:`TPIOC_START_W] != 20'h0_0000) begin
            start_nxt = `TPIOC_START_MAX;
          end else if (merged[`TPIOC_START_W-1:0] < `TPIOC_START_MIN) begin
            start_nxt = `TPIOC_START_MIN;
          end else if (merged[`TPIOC_START_W-1:0] > `TPIOC_START_MAX) begin
            start_nxt = `TPIOC_START_MAX;
          end else begin
            start_nxt = merged[`TPIOC_START_W-1:0];
          end
        end
        `TPIOC_ADDR_IRQ_MASK: begin
          merged   = lane_merge(mask_word, avs_writedata, avs_byteenable);
          mask_nxt = merged[`TPIOC_EVT_W-1:0];
        end
        default: begin
          merged = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_r  <= tpioc_pkg::tpioc_mode_off;
      start_r <= `TPIOC_START_DEFAULT;
      mask_r  <= `TPIOC_MASK_DEFAULT;
    end else begin
      mode_r  <= mode_nxt;
      start_r <= start_nxt;
      mask_r  <= mask_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts

  // Sticky trip onsets; a read clears, a new onset in that cycle survives
  always_comb begin
    irq_nxt = irq_r;
    if (rd_take && (avs_address == `TPIOC_ADDR_IRQ_STATUS)) begin
      irq_nxt = '0;
    end
    irq_nxt = irq_nxt | evt;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_r <= '0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // Level interrupt while any unmasked onset is pending
  assign irq_out = |(irq_r & mask_r);

endmodule

`default_nettype wire

/* tpioc_assertions.sv */
/* Port assertions for the overcurrent block.
   Assumes one clock and a bus master that holds each request until served. */
`timescale 1ns/1ns
`default_nettype none
`include "tpioc_params.svh"
module tpioc_assertions (
  input wire logic                     clk_sys,
  input wire logic                     rst,
  input wire logic                     avs_read,
  input wire logic                     avs_write,
  input wire logic [31:0]              avs_readdata,
  input wire logic                     avs_waitrequest,
  input wire logic                     function_inhibit_in,
  input wire logic                     threshold_doubling_in,
  input wire logic [`TPIOC_MEAS_W-1:0] phase_a_fundamental_rms,
  input wire logic [`TPIOC_MEAS_W-1:0] phase_a_peak_value,
  input wire logic                     phase_a_trip_out,
  input wire logic                     phase_b_trip_out,
  input wire logic                     phase_c_trip_out,
  input wire logic                     any_phase_trip_out
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Trip path relations
  gen_or_a: assert property (
    any_phase_trip_out == (phase_a_trip_out | phase_b_trip_out | phase_c_trip_out))
    else $error("general trip is not the OR of the phases");
  inhibit_quiet_a: assert property (
    function_inhibit_in |=> !any_phase_trip_out && !phase_a_trip_out)
    else $error("trip while inhibited");
  trip_cause_a: assert property (
    phase_a_trip_out |->
      $past(phase_a_peak_value > 16'h0014 || phase_a_fundamental_rms > 16'h0014))
    else $error("phase a trip without current above minimum");
  double_thr_a: assert property (
    threshold_doubling_in && phase_a_peak_value <= 16'h0028
      && phase_a_fundamental_rms <= 16'h0028 |=> !phase_a_trip_out)
    else $error("phase a trip below doubled minimum");
  ////////////////////////////////////////
  // Register bus handshake
  wait_first_a: assert property (
    (avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait cycle at request start");
  wait_once_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  idle_nowait_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait request while idle");
  read_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved outside a read");
endmodule

bind tpioc_phase_instant_overcurrent tpioc_assertions chk_u (
  .clk_sys, .rst, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .function_inhibit_in,
  .threshold_doubling_in, .phase_a_fundamental_rms, .phase_a_peak_value, .phase_a_trip_out,
  .phase_b_trip_out, .phase_c_trip_out, .any_phase_trip_out);
`default_nettype wire

/* tpioc_meas_model.sv */
/* Upstream measurement stages: per-phase peak and fundamental values.
   Assumes the bench raises load for one clock to hand over new values. */
`timescale 1ns/1ns
`default_nettype none
module tpioc_meas_model (
  input  wire logic        clk_sys,
  input  wire logic        load,
  input  wire logic [15:0] pk_in [3],
  input  wire logic [15:0] rm_in [3],
  output var  logic [15:0] pk_out [3] = '{default: 16'h0000},
  output var  logic [15:0] rm_out [3] = '{default: 16'h0000}
);
  // Each phase keeps its own peak and fundamental value until reloaded
  always @(posedge clk_sys) begin
    if (load) begin
      pk_out <= pk_in;
      rm_out <= rm_in;
    end
  end
endmodule
`default_nettype wire

/* tpioc_phase_instant_overcurrent_bench.sv */
/* Self-checking bench for the overcurrent block.
   Assumes the design, its header and the measurement model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`include "tpioc_params.svh"
module tpioc_phase_instant_overcurrent_bench;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq_out;
  logic        inh = 1'b0;
  logic        dbl = 1'b0;
  logic        load = 1'b0;
  logic [15:0] pk [3] = '{default: 16'h0};
  logic [15:0] rm [3] = '{default: 16'h0};
  logic [15:0] pkm [3];
  logic [15:0] rmm [3];
  wire  [3:0]  trips;
  logic [1:0]  mode = 2'h0;
  logic [11:0] start = 12'h0C8;
  logic [31:0] q;
  logic        inh_s = 1'b0;
  logic        dbl_s = 1'b0;
  int          failures = 0;
  int          n_checks = 0;

  // Clock, measurement model and the block
  initial forever #2 clk_sys = ~clk_sys;
  tpioc_meas_model meas (.clk_sys, .load, .pk_in(pk), .rm_in(rm), .pk_out(pkm), .rm_out(rmm));
  tpioc_phase_instant_overcurrent dut (
    .clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .function_inhibit_in(inh), .threshold_doubling_in(dbl),
    .phase_a_fundamental_rms(rmm[0]), .phase_b_fundamental_rms(rmm[1]),
    .phase_c_fundamental_rms(rmm[2]), .phase_a_peak_value(pkm[0]),
    .phase_b_peak_value(pkm[1]), .phase_c_peak_value(pkm[2]), .phase_a_trip_out(trips[0]),
    .phase_b_trip_out(trips[1]), .phase_c_trip_out(trips[2]), .any_phase_trip_out(trips[3]),
    .irq_out);
  ////////////////////////////////////////
  // Expected trips: strict compare against start, doubled on request
  function automatic logic [3:0] exp_trips(input logic [15:0] p [3], input logic [15:0] r [3],
                                           input logic i, input logic d);
    logic [3:0]  t;
    logic [16:0] thr;
    thr = {5'h00, start} << d;
    for (int k = 0; k < 3; k++)
      t[k] = !i && (mode == 2'h1 ? p[k] > thr : mode == 2'h2 && r[k] > thr);
    t[3] = |t[2:0];
    return t;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // One bus access, called just after a rising edge; held until waitrequest is seen low
  // at an edge, where read data are taken; only the watchdog ends a hung wait
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !w;
    avs_write <= w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] d);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(q, d);
  endtask

  // New measures and binary inputs; trips move one cycle after the block sees them
  task automatic apply();
    logic [3:0] old;
    old = exp_trips(pkm, rmm, inh, dbl);
    load <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
    inh <= inh_s;
    dbl <= dbl_s;
    #1;
    chk(trips, old);
    @(posedge clk_sys);
    #1;
    chk(trips, exp_trips(pk, rm, inh_s, dbl_s));
    @(posedge clk_sys);
  endtask

  task automatic test_done();
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  // Watchdog
  initial begin
    #200000;
    failures++;
    test_done();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h95AE));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(`TPIOC_ADDR_CTRL, 32'h0);
    rd(`TPIOC_ADDR_START, 32'hC8);
    rd(`TPIOC_ADDR_IRQ_MASK, 32'h0);
    wr(`TPIOC_ADDR_STATUS, 32'hF);
    rd(`TPIOC_ADDR_STATUS, 32'h0);
    rd(5'h14, 32'h0);
    wr(`TPIOC_ADDR_START, 32'h5);
    rd(`TPIOC_ADDR_START, 32'h14);
    wr(`TPIOC_ADDR_START, 32'hFFF);
    rd(`TPIOC_ADDR_START, 32'hBB8);
    wr(`TPIOC_ADDR_START, 32'hC8);
    bus(1'b1, `TPIOC_ADDR_START, 32'h100, 4'h2);
    rd(`TPIOC_ADDR_START, 32'h1C8);
    wr(`TPIOC_ADDR_START, 32'hC8);
    wr(`TPIOC_ADDR_CTRL, 32'h3);
    rd(`TPIOC_ADDR_CTRL, 32'h0);
    pk = '{default: 16'hFFFF};
    rm = '{default: 16'hFFFF};
    apply();
    // One phase just over the threshold, the unused measure far above it
    for (int m = 1; m < 3; m++) begin
      mode = 2'(m);
      wr(`TPIOC_ADDR_CTRL, 32'(m));
      rd(`TPIOC_ADDR_CTRL, 32'(m));
      for (int i = 0; i < 3; i++) begin
        pk = '{default: (m == 1) ? 16'h00C8 : 16'hFFFF};
        rm = '{default: (m == 1) ? 16'hFFFF : 16'h00C8};
        if (m == 1) pk[i] = 16'h00C9;
        else rm[i] = 16'h00C9;
        apply();
        rd(`TPIOC_ADDR_STATUS, 32'(4'h8 | 4'h1 << i));
      end
    end
    // Random settings with measures around the threshold
    for (int k = 0; k < 60; k++) begin
      mode = 2'($urandom_range(1, 2));
      start = (k == 0) ? 12'h014 : (k == 1) ? 12'hBB8 : 12'($urandom_range(20, 3000));
      dbl_s = (k == 0) ? 1'b1 : 1'($urandom);
      inh_s = ($urandom_range(0, 5) == 0);
      wr(`TPIOC_ADDR_CTRL, {30'h0, mode});
      wr(`TPIOC_ADDR_START, {20'h0, start});
      // First pass sits exactly on the doubled minimum threshold
      for (int i = 0; i < 3; i++) begin
        pk[i] = 16'(({4'h0, start} << dbl_s) + ((k == 0) ? 32'h2 : $urandom_range(0, 4)) - 2);
        rm[i] = 16'(({4'h0, start} << dbl_s) + ((k == 0) ? 32'h2 : $urandom_range(0, 4)) - 2);
      end
      apply();
    end
    // Masked and unmasked onsets, cleared by reading
    mode = 2'h1;
    start = 12'h0C8;
    inh_s = 1'b0;
    dbl_s = 1'b0;
    wr(`TPIOC_ADDR_CTRL, 32'h1);
    wr(`TPIOC_ADDR_START, 32'hC8);
    pk = '{default: 16'h0};
    rm = '{default: 16'h0};
    apply();
    bus(1'b0, `TPIOC_ADDR_IRQ_STATUS, 32'h0, 4'hF);
    pk[0] = 16'h012C;
    apply();
    chk(irq_out, 32'h0);
    rd(`TPIOC_ADDR_IRQ_STATUS, 32'h9);
    rd(`TPIOC_ADDR_IRQ_STATUS, 32'h0);
    wr(`TPIOC_ADDR_IRQ_MASK, 32'h1);
    pk[0] = 16'h0;
    apply();
    pk[0] = 16'h012C;
    apply();
    chk(irq_out, 32'h1);
    rd(`TPIOC_ADDR_IRQ_STATUS, 32'h9);
    chk(irq_out, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
